// ===== logic/tdcod_pkg.sv
package tdcod_pkg;

    // ----------------------------------------------------------------
    // Opcode layout
    // ----------------------------------------------------------------
    localparam int          OP_W                   = 8;
    localparam logic [3:0]  OP_BITS                = 4'h8;
    localparam logic [3:0]  OP_LAST_BIT            = 4'h7;

    // ----------------------------------------------------------------
    // Action opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0]  OP_TOF_SINGLE_GO       = 8'h01;
    localparam logic [7:0]  OP_TOF_BIDIR_GO        = 8'h03;
    localparam logic [7:0]  OP_TEMP_SINGLE_GO      = 8'h04;
    localparam logic [7:0]  OP_TEMP_DOUBLE_GO      = 8'h05;
    localparam logic [7:0]  OP_PARTIAL_INIT        = 8'h70;
    localparam logic [7:0]  OP_SOFT_RESET          = 8'h50;

    // ----------------------------------------------------------------
    // Read opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0]  OP_RD_DOWN_ECHO_SEVENTH   = 8'hbf;
    localparam logic [7:0]  OP_RD_DOWN_ECHO_EIGHTH    = 8'hc0;
    localparam logic [7:0]  OP_RD_DOWN_ECHO_TOTAL     = 8'hc1;
    localparam logic [7:0]  OP_RD_THERMAL_PORT_FIRST  = 8'hc2;
    localparam logic [7:0]  OP_RD_THERMAL_PORT_SECOND = 8'hc3;
    localparam logic [7:0]  OP_RD_THERMAL_PORT_THIRD  = 8'hc4;
    localparam logic [7:0]  OP_RD_THERMAL_PORT_FOURTH = 8'hc5;
    localparam logic [7:0]  OP_RD_FIRST_WAVE_WIDTH    = 8'hd0;
    localparam logic [7:0]  OP_RD_FIRST_ECHO_WIDTH    = 8'hd1;
    localparam logic [7:0]  OP_RD_STATUS              = 8'hd2;
    localparam logic [7:0]  OP_RD_LINK_CHECK          = 8'hd3;
    localparam logic [7:0]  OP_RD_CALIBRATION         = 8'hd4;

    // ----------------------------------------------------------------
    // Link check width and pin layout
    // ----------------------------------------------------------------
    localparam int          LINK_W                 = 8;
    localparam int          PIN_N                  = 3;
    localparam int          PIN_SEL                = 0;
    localparam int          PIN_SCK                = 1;
    localparam int          PIN_SI                 = 2;
    localparam logic [2:0]  PIN_RESET              = 3'h1;

    // ----------------------------------------------------------------
    // Measurement sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [6:0] {
        SEQ_IDLE     = 7'h01,
        SEQ_TOF_ONE  = 7'h02,
        SEQ_TOF_UP   = 7'h04,
        SEQ_TOF_DOWN = 7'h08,
        SEQ_TEMP_ONE = 7'h10,
        SEQ_TEMP_A   = 7'h20,
        SEQ_TEMP_B   = 7'h40
    } tdcod_seq_t;

endpackage

// ===== logic/tdcod_top.sv
`timescale 1ns/1ps
`default_nettype none

module tdcod_top #(
    parameter int DATA_W = 32
) (
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    input  wire logic              slave_select_n,
    input  wire logic              sck,
    input  wire logic              si,
    output logic                   soOut,
    output logic                   soOe_n,
    input  wire logic [DATA_W-1:0] downEchoSeventh,
    input  wire logic [DATA_W-1:0] downEchoEighth,
    input  wire logic [DATA_W-1:0] downEchoTotal,
    input  wire logic [DATA_W-1:0] thermalFirst,
    input  wire logic [DATA_W-1:0] thermalSecond,
    input  wire logic [DATA_W-1:0] thermalThird,
    input  wire logic [DATA_W-1:0] thermalFourth,
    input  wire logic [DATA_W-1:0] firstWaveWidth,
    input  wire logic [DATA_W-1:0] firstEchoWidth,
    input  wire logic [DATA_W-1:0] statusWord,
    input  wire logic [DATA_W-1:0] configZero,
    input  wire logic [DATA_W-1:0] calibrationWord,
    input  wire logic              tofDone,
    input  wire logic              tempDone,
    output logic                   tofStart,
    output logic                   tofDirDown,
    output logic                   tempStart,
    output logic                   tempSecond,
    output logic                   measBusy,
    output logic                   clearResults,
    output logic                   softReset
);
    import tdcod_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [PIN_N-1:0] pinRaw;
    logic [PIN_N-1:0] syncA;
    logic [PIN_N-1:0] syncB;
    logic [PIN_N-1:0] syncC;
    logic [PIN_N-1:0] pinClean;
    logic [PIN_N-1:0] pinPrev;

    assign pinRaw = {si, sck, slave_select_n};

    // Three stages per pin, value taken once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < PIN_N; gi++) begin : g_sync
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    syncA[gi]    <= PIN_RESET[gi];
                    syncB[gi]    <= PIN_RESET[gi];
                    syncC[gi]    <= PIN_RESET[gi];
                    pinClean[gi] <= PIN_RESET[gi];
                    pinPrev[gi]  <= PIN_RESET[gi];
                end else begin
                    syncA[gi]    <= pinRaw[gi];
                    syncB[gi]    <= syncA[gi];
                    syncC[gi]    <= syncB[gi];
                    pinClean[gi] <= (syncB[gi] == syncC[gi]) ? syncC[gi] : pinClean[gi];
                    pinPrev[gi]  <= pinClean[gi];
                end
            end
        end
    endgenerate

    // Edge and select decoding
    wire selActive = ~pinClean[PIN_SEL];
    wire sckRise   = selActive & pinClean[PIN_SCK] & ~pinPrev[PIN_SCK];
    wire sckFall   = selActive & ~pinClean[PIN_SCK] & pinPrev[PIN_SCK];
    wire siBit     = pinClean[PIN_SI];

    // ----------------------------------------------------------------
    // Opcode capture
    // ----------------------------------------------------------------
    logic [OP_W-1:0] opShift;
    logic [3:0]      bitCnt;

    // Only the first byte of a frame is an opcode; later bits are ignored
    wire             opBitTake  = sckRise & (bitCnt != OP_BITS);
    wire             opDone     = sckRise & (bitCnt == OP_LAST_BIT);
    wire [OP_W-1:0]  nextOpcode = {opShift[OP_W-2:0], siBit};
    wire [3:0]       next_bitCnt = bitCnt + 4'h1;

    // Shift in MSB first on rising clock, restart when select rises
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            opShift <= '0;
            bitCnt  <= '0;
        end else if (!selActive) begin
            bitCnt  <= '0;
        end else if (opBitTake) begin
            opShift <= nextOpcode;
            bitCnt  <= next_bitCnt;
        end
    end

    // ----------------------------------------------------------------
    // Opcode decode
    // ----------------------------------------------------------------
    wire isTofSingle  = opDone & (nextOpcode == OP_TOF_SINGLE_GO);
    wire isTofBidir   = opDone & (nextOpcode == OP_TOF_BIDIR_GO);
    wire isTempSingle = opDone & (nextOpcode == OP_TEMP_SINGLE_GO);
    wire isTempDouble = opDone & (nextOpcode == OP_TEMP_DOUBLE_GO);
    wire isInit       = opDone & (nextOpcode == OP_PARTIAL_INIT);
    wire isPor        = opDone & (nextOpcode == OP_SOFT_RESET);

    wire selSeventh = nextOpcode == OP_RD_DOWN_ECHO_SEVENTH;
    wire selEighth  = nextOpcode == OP_RD_DOWN_ECHO_EIGHTH;
    wire selTotal   = nextOpcode == OP_RD_DOWN_ECHO_TOTAL;
    wire selTherm1  = nextOpcode == OP_RD_THERMAL_PORT_FIRST;
    wire selTherm2  = nextOpcode == OP_RD_THERMAL_PORT_SECOND;
    wire selTherm3  = nextOpcode == OP_RD_THERMAL_PORT_THIRD;
    wire selTherm4  = nextOpcode == OP_RD_THERMAL_PORT_FOURTH;
    wire selWave    = nextOpcode == OP_RD_FIRST_WAVE_WIDTH;
    wire selEcho    = nextOpcode == OP_RD_FIRST_ECHO_WIDTH;
    wire selStatus  = nextOpcode == OP_RD_STATUS;
    wire selLink    = nextOpcode == OP_RD_LINK_CHECK;
    wire selCal     = nextOpcode == OP_RD_CALIBRATION;

    // Unlisted codes match nothing and so trigger nothing
    wire anyRead = selSeventh | selEighth | selTotal | selTherm1 | selTherm2
                 | selTherm3 | selTherm4 | selWave | selEcho | selStatus
                 | selLink | selCal;
    wire readHit = opDone & anyRead;

    // Link check word is left aligned so its eight bits go out first
    wire [DATA_W-1:0] linkWord = {configZero[LINK_W-1:0], {(DATA_W-LINK_W){1'b0}}};

    // Read source selection
    wire [DATA_W-1:0] readWord =
        selSeventh ? downEchoSeventh :
        selEighth  ? downEchoEighth  :
        selTotal   ? downEchoTotal   :
        selTherm1  ? thermalFirst    :
        selTherm2  ? thermalSecond   :
        selTherm3  ? thermalThird    :
        selTherm4  ? thermalFourth   :
        selWave    ? firstWaveWidth  :
        selEcho    ? firstEchoWidth  :
        selStatus  ? statusWord      :
        selLink    ? linkWord        :
        selCal     ? calibrationWord :
                     '0;

    // ----------------------------------------------------------------
    // Serial read-out
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] outShift;
    logic              driving;
    logic              skipFall;

    // Load after the opcode, MSB first; the fall closing bit eight does not shift
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            outShift <= '0;
            driving  <= 1'b0;
            skipFall <= 1'b0;
        end else if (!selActive) begin
            driving  <= 1'b0;
            skipFall <= 1'b0;
        end else if (readHit) begin
            outShift <= readWord;
            driving  <= 1'b1;
            skipFall <= 1'b1;
        end else if (sckFall && driving) begin
            skipFall <= 1'b0;
            outShift <= skipFall ? outShift : {outShift[DATA_W-2:0], 1'b0};
        end
    end

    assign soOut  = outShift[DATA_W-1];
    assign soOe_n = ~driving;         // Low while the output is driven

    // ----------------------------------------------------------------
    // Register control pulses
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            clearResults <= 1'b0;
            softReset    <= 1'b0;
        end else begin
            clearResults <= isInit;
            softReset    <= isPor;
        end
    end

    // ----------------------------------------------------------------
    // Measurement sequencer
    // ----------------------------------------------------------------
    tdcod_seq_t seqState;
    tdcod_seq_t next_seqState;
    logic       next_tofStart;
    logic       next_tempStart;

    // Starts are taken only while idle; soft reset aborts any sequence
    always_comb begin
        next_seqState  = seqState;
        next_tofStart  = 1'b0;
        next_tempStart = 1'b0;
        unique case (seqState)
            SEQ_IDLE: begin
                if (isTofSingle) begin
                    next_seqState = SEQ_TOF_ONE;
                    next_tofStart = 1'b1;
                end else if (isTofBidir) begin
                    next_seqState = SEQ_TOF_UP;
                    next_tofStart = 1'b1;
                end else if (isTempSingle) begin
                    next_seqState  = SEQ_TEMP_ONE;
                    next_tempStart = 1'b1;
                end else if (isTempDouble) begin
                    next_seqState  = SEQ_TEMP_A;
                    next_tempStart = 1'b1;
                end
            end
            SEQ_TOF_ONE: begin
                if (tofDone) next_seqState = SEQ_IDLE;
            end
            SEQ_TOF_UP: begin
                if (tofDone) begin
                    next_seqState = SEQ_TOF_DOWN;
                    next_tofStart = 1'b1;
                end
            end
            SEQ_TOF_DOWN: begin
                if (tofDone) next_seqState = SEQ_IDLE;
            end
            SEQ_TEMP_ONE: begin
                if (tempDone) next_seqState = SEQ_IDLE;
            end
            SEQ_TEMP_A: begin
                if (tempDone) begin
                    next_seqState  = SEQ_TEMP_B;
                    next_tempStart = 1'b1;
                end
            end
            SEQ_TEMP_B: begin
                if (tempDone) next_seqState = SEQ_IDLE;
            end
            default: next_seqState = SEQ_IDLE;
        endcase
        if (isPor) begin
            next_seqState  = SEQ_IDLE;
            next_tofStart  = 1'b0;
            next_tempStart = 1'b0;
        end
    end

    // Sequencer registers and direction / pass levels
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            seqState  <= SEQ_IDLE;
            tofStart  <= 1'b0;
            tempStart <= 1'b0;
        end else begin
            seqState  <= next_seqState;
            tofStart  <= next_tofStart;
            tempStart <= next_tempStart;
        end
    end

    assign tofDirDown = seqState == SEQ_TOF_DOWN;
    assign tempSecond = seqState == SEQ_TEMP_B;
    assign measBusy   = seqState != SEQ_IDLE;

endmodule

`default_nettype wire

// ===== sim/tdcod_host.sv
`timescale 1ns/1ps
`default_nettype none

module tdcod_host #(
    parameter int DATA_W = 32
) (
    input  wire logic ref_clk,
    input  wire logic soOut,
    input  wire logic soOe_n,
    output logic      slave_select_n,
    output logic      sck,
    output logic      si
);
    logic idle;
    logic soLast;
    // Released line shows the inverse of its last driven value
    wire  soLine = (soOe_n === 1'b0) ? soOut : ~soLast;

    initial begin
        slave_select_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        idle = 1'b1;
        soLast = 1'b0;
    end

    // Remember what the device drove and scramble si between frames
    always @(posedge ref_clk) begin
        if (soOe_n === 1'b0) soLast <= soOut;
        if (idle) si <= #1 ~si;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // One frame: opcode MSB first, then data clocks sampled on each rise
    task automatic xfer(input logic [7:0] op, input int nOp, input int nData,
                        output logic [DATA_W-1:0] rd);
        rd = '0;
        hold(1);
        idle = 1'b0;
        slave_select_n = 1'b0;
        hold(6);
        for (int i = 0; i < nOp + nData; i++) begin
            si = (i < 8) ? op[3'(7 - i)] : 1'b0;
            sck = 1'b0;
            hold(6);
            sck = 1'b1;
            if (i >= 8) rd = {rd[DATA_W-2:0], soLine};
            hold(6);
        end
        sck = 1'b0;
        hold(6);
        slave_select_n = 1'b1;
        idle = 1'b1;
        hold(6);
    endtask
endmodule

`default_nettype wire

// ===== sim/tdcod_top_chk.sv
`timescale 1ns/1ps
`default_nettype none

module tdcod_top_chk (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic slave_select_n,
    input wire logic soOe_n,
    input wire logic tofDone,
    input wire logic tempDone,
    input wire logic tofStart,
    input wire logic tofDirDown,
    input wire logic tempStart,
    input wire logic tempSecond,
    input wire logic measBusy,
    input wire logic clearResults,
    input wire logic softReset
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    // ----------------------------------------------------------------
    // Command pulses and sequencer
    // ----------------------------------------------------------------
    AST_CLR_ALONE: assert property (clearResults |-> !tofStart && !tempStart
        && !softReset ##1 !clearResults) else $error("clear pulse not alone");
    AST_SRST_ABORT: assert property (softReset |=> !measBusy && !softReset)
        else $error("soft reset did not abort");
    AST_TOF_LEG: assert property (tofDone && measBusy && !tofDirDown |=>
        !measBusy || (tofStart && tofDirDown)) else $error("bad step after first leg");
    AST_BIDIR_END: assert property (tofDone && tofDirDown |=> !measBusy && !tofDirDown)
        else $error("bidirectional run did not end");
    AST_TEMP_LEG: assert property (tempDone && measBusy && !tempSecond |=>
        !measBusy || (tempStart && tempSecond)) else $error("bad step after first pass");
    AST_TEMP_END: assert property (tempDone && tempSecond |=> !measBusy && !tempSecond)
        else $error("repeated temperature run did not end");
    AST_FRESH_START: assert property ((tofStart && !$past(tofDone))
        || (tempStart && !$past(tempDone)) |-> !$past(measBusy)) else $error("start while busy");
    AST_BUSY_CAUSE: assert property ($rose(measBusy) |-> tofStart || tempStart)
        else $error("busy without a start");
    AST_LEG_BUSY: assert property (tofDirDown || tempSecond |-> measBusy)
        else $error("second leg flag outside a run");

    // ----------------------------------------------------------------
    // Serial output enable
    // ----------------------------------------------------------------
    AST_SO_RELEASE: assert property (slave_select_n [*6] |-> soOe_n)
        else $error("output driven while deselected");
    AST_SO_SELECT: assert property ($fell(soOe_n) |-> !slave_select_n)
        else $error("output enabled without select");

    COV_BIDIR: cover property (tofStart && tofDirDown);
    COV_TEMP2: cover property (tempStart && tempSecond);
    COV_READ: cover property ($fell(soOe_n));
    COV_ABORT: cover property (softReset && $past(measBusy));
endmodule

bind tdcod_top tdcod_top_chk tdcod_top_chk_i (
    .ref_clk(ref_clk), .resetn(resetn), .slave_select_n(slave_select_n),
    .soOe_n(soOe_n), .tofDone(tofDone), .tempDone(tempDone), .tofStart(tofStart),
    .tofDirDown(tofDirDown), .tempStart(tempStart), .tempSecond(tempSecond),
    .measBusy(measBusy), .clearResults(clearResults), .softReset(softReset)
);

`default_nettype wire

// ===== sim/tdcod_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module tdcod_top_tb;
    import tdcod_pkg::*;
    logic        ref_clk, resetn, slave_select_n, sck, si, soOut, soOe_n;
    logic        tofDone, tempDone, tofStart, tofDirDown, tempStart, tempSecond;
    logic        measBusy, clearResults, softReset;
    logic [31:0] word [12];
    logic [3:0]  nTof, nTemp, nClr, nSrst, nDown, nSec;
    int          tofWait, tempWait, engDelay, errorCnt, nChecks;
    int          seed = 32'h91d64253;
    logic [31:0] rd;
    logic [7:0]  op;
    wire  [23:0] seenCnt = {nTof, nTemp, nClr, nSrst, nDown, nSec};

    tdcod_top tdcod_top_i (
        .ref_clk(ref_clk), .resetn(resetn), .slave_select_n(slave_select_n), .sck(sck),
        .si(si), .soOut(soOut), .soOe_n(soOe_n), .downEchoSeventh(word[0]),
        .downEchoEighth(word[1]), .downEchoTotal(word[2]), .thermalFirst(word[3]),
        .thermalSecond(word[4]), .thermalThird(word[5]), .thermalFourth(word[6]),
        .firstWaveWidth(word[7]), .firstEchoWidth(word[8]), .statusWord(word[9]),
        .configZero(word[10]), .calibrationWord(word[11]), .tofDone(tofDone),
        .tempDone(tempDone), .tofStart(tofStart), .tofDirDown(tofDirDown),
        .tempStart(tempStart), .tempSecond(tempSecond), .measBusy(measBusy),
        .clearResults(clearResults), .softReset(softReset));
    tdcod_host tdcod_host_i (
        .ref_clk(ref_clk), .soOut(soOut), .soOe_n(soOe_n),
        .slave_select_n(slave_select_n), .sck(sck), .si(si));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Engines answer each start after engDelay cycles; pulses are counted
    always @(posedge ref_clk) begin
        tofDone <= #1 (tofWait == 1);
        tempDone <= #1 (tempWait == 1);
        tofWait <= (tofStart === 1'b1) ? engDelay : (tofWait > 0 ? tofWait - 1 : 0);
        tempWait <= (tempStart === 1'b1) ? engDelay : (tempWait > 0 ? tempWait - 1 : 0);
        nTof <= nTof + 4'(tofStart === 1'b1);
        nTemp <= nTemp + 4'(tempStart === 1'b1);
        nClr <= nClr + 4'(clearResults === 1'b1);
        nSrst <= nSrst + 4'(softReset === 1'b1);
        nDown <= nDown + 4'((tofStart & tofDirDown) === 1'b1);
        nSec <= nSec + 4'((tempStart & tempSecond) === 1'b1);
    end

    function automatic logic [23:0] expCnt(input logic [7:0] o);
        case (o)
            OP_TOF_SINGLE_GO:  return 24'h100000;
            OP_TOF_BIDIR_GO:   return 24'h200010;
            OP_TEMP_SINGLE_GO: return 24'h010000;
            OP_TEMP_DOUBLE_GO: return 24'h020001;
            OP_PARTIAL_INIT:   return 24'h001000;
            OP_SOFT_RESET:     return 24'h000100;
            default:           return 24'h000000;
        endcase
    endfunction

    function automatic int rdIdx(input logic [7:0] o);
        if (o >= 8'hbf && o <= 8'hc5) return int'(o - 8'hbf);
        if (o >= 8'hd0 && o <= 8'hd4) return int'(o - 8'hd0) + 7;
        return -1;
    endfunction

    function automatic logic [31:0] expRd(input logic [7:0] o);
        if (o == OP_RD_LINK_CHECK) return {word[10][7:0], 24'h000000};
        return word[rdIdx(o)];
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        nChecks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic clrCnt();
        @(posedge ref_clk);
        {nTof, nTemp, nClr, nSrst, nDown, nSec} <= #1 24'h0;
        @(posedge ref_clk);
        #1;
    endtask

    // One frame, wait for the run to finish, compare counts and read data
    task automatic runOp(input logic [7:0] o, input int nOp);
        logic full;
        full = (nOp == 8);
        engDelay = 3 + int'($unsigned($random(seed)) % 18);
        foreach (word[j]) word[j] = $random(seed);
        clrCnt();
        tdcod_host_i.xfer(o, nOp, (full && rdIdx(o) >= 0) ? 32 : 0, rd);
        for (int k = 0; k < 3000 && measBusy !== 1'b0; k++) @(posedge ref_clk);
        repeat (4) @(posedge ref_clk);
        check("idle", 32'h0, {31'h0, measBusy});
        check("counts", {8'h0, full ? expCnt(o) : 24'h0}, {8'h0, seenCnt});
        if (full && rdIdx(o) >= 0) check("read", expRd(o), rd);
        check("so_release", 32'h1, {31'h0, soOe_n});
        $display("test op %h bits %0d done", o, nOp);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", nChecks, errorCnt);
        if (errorCnt == 0 && nChecks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge ref_clk);
        errorCnt++;
        summarize();
    end

    initial begin
        resetn = 1'b0;
        {tofDone, tempDone, tofWait, tempWait, engDelay, errorCnt, nChecks} = '0;
        {nTof, nTemp, nClr, nSrst, nDown, nSec} = 24'h0;
        foreach (word[j]) word[j] = 32'h0;
        repeat (6) @(posedge ref_clk);
        #1 resetn = 1'b1;
        repeat (6) @(posedge ref_clk);
        for (int i = 0; i < 6; i++) runOp(8'({8'h01, 8'h03, 8'h04, 8'h05, 8'h70, 8'h50} >> (40 - 8 * i)), 8);
        for (int i = 0; i < 12; i++) runOp(i < 7 ? 8'(8'hbf + i) : 8'(8'hd0 + i - 7), 8);
        for (int i = 0; i < 10; i++) begin
            op = 8'($random(seed));
            runOp(op, 8);
        end
        runOp(OP_PARTIAL_INIT, 5);
        // Start refused while busy, then abort of a bidirectional run
        engDelay = 900;
        clrCnt();
        tdcod_host_i.xfer(OP_TOF_BIDIR_GO, 8, 0, rd);
        tdcod_host_i.xfer(OP_TEMP_SINGLE_GO, 8, 0, rd);
        tdcod_host_i.xfer(OP_SOFT_RESET, 8, 0, rd);
        repeat (4) @(posedge ref_clk);
        check("abort", 32'h0, {31'h0, measBusy});
        repeat (900) @(posedge ref_clk);
        check("busy_counts", 32'h100100, {8'h0, seenCnt});
        summarize();
    end
endmodule

`default_nettype wire
